// File: rtl/gsmc_pkg.sv
// Constants, carrier types and helpers for the pin-borrowing serial master
package gsmc_pkg;

  // Register bus geometry
  localparam int          ADDR_W    = 12;
  localparam int          DATA_W    = 8;

  // Register offsets
  localparam logic [11:0] CFG_OFS   = 12'h154;
  localparam logic [11:0] TX_OFS    = 12'h155;
  localparam logic [11:0] EXE_OFS   = 12'h156;
  localparam logic [11:0] STAT_OFS  = 12'h157;
  localparam logic [11:0] RX_OFS    = 12'h158;

  // Reset values
  localparam logic [7:0]  CFG_RST   = 8'h10;
  localparam logic [7:0]  TX_RST    = 8'h00;
  localparam logic [7:0]  ZERO_BYTE = 8'h00;

  // Field positions
  localparam int          CPOL_BIT  = 6;
  localparam int          CPHA_BIT  = 5;
  localparam int          SS_BIT    = 4;
  localparam int          EN_BIT    = 3;
  localparam int          LEN_LSB   = 0;
  localparam int          GO_BIT    = 0;
  localparam int          BUSY_BIT  = 0;

  // Pin slots: index 0..3 are general-purpose pins 3..6
  localparam int          PIN_SCLK  = 0;
  localparam int          PIN_MOSI  = 1;
  localparam int          PIN_MISO  = 2;
  localparam int          PIN_SS    = 3;
  localparam logic [3:0]  PIN_OE_SPI = 4'hB;

  // Timing on the link clock
  localparam int          LINK_PERIOD_NS = 15;
  localparam int          SCLK_HALF_NS   = 60;
  localparam int          HALF_CYC  = (SCLK_HALF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam logic [2:0]  HALF_LAST = 3'(HALF_CYC - 1);
  localparam int          SYNC_LAT  = 2;

  // Configuration fields as one carrier
  typedef struct packed {
    logic       cpol;
    logic       cpha;
    logic       ss;
    logic       en;
    logic [2:0] len;
  } gsmc_cfg_t;

  // Snapshot handed to the link domain at launch
  typedef struct packed {
    gsmc_cfg_t  cfg;
    logic [7:0] tx;
  } gsmc_job_t;

  // Gray order along idle, shift, tail, done
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_TAIL  = 2'b11,
    ST_DONE  = 2'b10
  } gsmc_state_t;

  // Length code to bit count, code zero meaning eight
  function automatic logic [3:0] gsmc_nbits(input logic [2:0] len);
    gsmc_nbits = (len == 3'h0) ? 4'h8 : {1'b0, len};
  endfunction : gsmc_nbits

endpackage : gsmc_pkg

// File: rtl/gsmc_top.sv
// Serial master on borrowed pins: register file, launch handshake, link engine
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

//
// Overview of operation
// R1: Polarity 0 idles clock low, pulses high; 1 idles high, pulses low.
// R2: Phase 0 samples slave data on first transition, 1 on second.
// R3: Select pin follows the select-level field directly, low for 0, high for 1.
// R4: Enable bit 1 hands pins 3 to 6 to the master; 0 disables it.
// R5: While enabled, ordinary pin settings for pins 3 to 6 are ignored.
// R6: Length code 000 transfers eight bits; 001 to 111 transfer one to seven.
// R7: Transmit byte shifts out on master-out, least significant bit first.
// R8: Writing 1 to execute launches one transaction; execute always reads 0. Here the write is ignored while enable is 0 or busy.
// R9: Exactly length clock cycles per transaction; select left to software.
module gsmc_top
  import gsmc_pkg::*;
(
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_rst,
  input  wire logic                      i_link_clk,
  input  wire logic [gsmc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [gsmc_pkg::DATA_W-1:0] i_wdata,
  input  wire logic                      i_wr,
  input  wire logic                      i_rd,
  output logic      [gsmc_pkg::DATA_W-1:0] o_rdata,
  input  wire logic [3:0]                i_gpio_out,
  input  wire logic [3:0]                i_gpio_oe,
  input  wire logic [3:0]                i_pin_in,
  output logic      [3:0]                o_pin_out,
  output logic      [3:0]                o_pin_oe,
  output logic                           o_busy
);
  import gsmc_pkg::*;

  // Reference domain state
  gsmc_cfg_t   cfg_reg;
  logic [7:0]  tx_reg;
  gsmc_job_t   job_reg;
  logic        req_tog_reg;
  logic        ack_s1_reg;
  logic        ack_s2_reg;
  logic        ack_d_reg;
  logic [7:0]  rx_reg;
  logic [7:0]  rdata_reg;
  logic        busy_reg;
  logic        busy;
  logic        go_write;

  // Link domain state
  logic        req_s1_reg;
  logic        req_s2_reg;
  logic        req_d_reg;
  logic [10:0] lvl_s1_reg;
  logic [10:0] lvl_s2_reg;
  logic        miso_s1_reg;
  logic        miso_s2_reg;
  gsmc_state_t state_reg;
  logic [2:0]  half_cnt_reg;
  logic [4:0]  edge_cnt_reg;
  logic [4:0]  nedges_reg;
  logic [3:0]  nbits_reg;
  logic        cpol_reg;
  logic        cpha_reg;
  logic        sclk_reg;
  logic        mosi_reg;
  logic [7:0]  txsh_reg;
  logic [7:0]  rxsh_reg;
  logic [1:0]  samp_d_reg;
  logic        ack_tog_reg;
  logic [7:0]  rx_hold_reg;
  logic [3:0]  pin_out_reg;
  logic [3:0]  pin_oe_reg;
  logic [4:0]  tog_cnt_reg;
  logic        start;
  logic        edge_now;
  logic        last_edge;
  logic        en_s;
  logic        ss_s;
  logic        cpol_s;
  logic [3:0]  gpo_s;
  logic [3:0]  gpoe_s;

  // Busy from request toggle against returned acknowledge
  assign busy     = req_tog_reg ^ ack_s2_reg;
  assign go_write = i_wr && (i_addr == EXE_OFS) && i_wdata[GO_BIT] && cfg_reg.en && !busy;

  // Configuration and transmit byte writes
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= gsmc_cfg_t'(CFG_RST[6:0]);
      tx_reg  <= TX_RST;
    end else if (i_wr) begin
      if (i_addr == CFG_OFS) begin
        cfg_reg <= gsmc_cfg_t'(i_wdata[6:0]);
      end
      if (i_addr == TX_OFS) begin
        tx_reg <= i_wdata;
      end
    end
  end

  // Launch: snapshot held stable until the link acknowledges
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      job_reg     <= '0;
      req_tog_reg <= 1'b0;
    end else if (go_write) begin // R8
      job_reg     <= '{cfg: cfg_reg, tx: tx_reg};
      req_tog_reg <= ~req_tog_reg;
    end
  end

  // Acknowledge toggle synchroniser; received byte taken on its edge
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ack_s1_reg <= 1'b0;
      ack_s2_reg <= 1'b0;
      ack_d_reg  <= 1'b0;
      rx_reg     <= ZERO_BYTE;
      busy_reg   <= 1'b0;
    end else begin
      ack_s1_reg <= ack_tog_reg;
      ack_s2_reg <= ack_s1_reg;
      ack_d_reg  <= ack_s2_reg;
      busy_reg   <= busy || go_write;
      if (ack_s2_reg ^ ack_d_reg) begin
        rx_reg <= rx_hold_reg; // Stable since the link edge that made the toggle
      end
    end
  end

  // Read data one cycle after the strobe; execute always reads zero
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= ZERO_BYTE;
    end else if (i_rd) begin
      case (i_addr)
        CFG_OFS:  rdata_reg <= {1'b0, cfg_reg};
        TX_OFS:   rdata_reg <= tx_reg;
        EXE_OFS:  rdata_reg <= ZERO_BYTE; // R8
        STAT_OFS: rdata_reg <= {7'h00, busy};
        RX_OFS:   rdata_reg <= rx_reg;
        default:  rdata_reg <= ZERO_BYTE;
      endcase
    end else begin
      rdata_reg <= ZERO_BYTE;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_busy  = busy_reg;

  // Request and level synchronisers into the link domain
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      req_s1_reg  <= 1'b0;
      req_s2_reg  <= 1'b0;
      req_d_reg   <= 1'b0;
      lvl_s1_reg  <= 11'h000;
      lvl_s2_reg  <= 11'h000;
      miso_s1_reg <= 1'b0;
      miso_s2_reg <= 1'b0;
    end else begin
      req_s1_reg  <= req_tog_reg;
      req_s2_reg  <= req_s1_reg;
      req_d_reg   <= req_s2_reg;
      lvl_s1_reg  <= {cfg_reg.cpol, cfg_reg.ss, cfg_reg.en, i_gpio_out, i_gpio_oe};
      lvl_s2_reg  <= lvl_s1_reg;
      miso_s1_reg <= i_pin_in[PIN_MISO];
      miso_s2_reg <= miso_s1_reg;
    end
  end

  assign {cpol_s, ss_s, en_s, gpo_s, gpoe_s} = lvl_s2_reg;
  assign start     = (req_s2_reg ^ req_d_reg) && (state_reg == ST_IDLE);
  assign edge_now  = (state_reg == ST_SHIFT) && (half_cnt_reg == HALF_LAST);
  assign last_edge = (edge_cnt_reg == nedges_reg - 5'h01);

  // Sequencer: one clock edge per half period, two per bit
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg    <= ST_IDLE;
      half_cnt_reg <= 3'h0;
      edge_cnt_reg <= 5'h00;
      nedges_reg   <= 5'h10;
      nbits_reg    <= 4'h8;
      cpol_reg     <= 1'b0;
      cpha_reg     <= 1'b0;
      ack_tog_reg  <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          half_cnt_reg <= 3'h0;
          edge_cnt_reg <= 5'h00;
          if (start) begin
            nbits_reg  <= gsmc_nbits(job_reg.cfg.len); // R6
            nedges_reg <= {gsmc_nbits(job_reg.cfg.len), 1'b0}; // R9
            cpol_reg   <= job_reg.cfg.cpol;
            cpha_reg   <= job_reg.cfg.cpha;
            state_reg  <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          half_cnt_reg <= edge_now ? 3'h0 : half_cnt_reg + 3'h1;
          if (edge_now) begin
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
            if (last_edge) begin
              state_reg <= ST_TAIL; // R9
            end
          end
        end
        ST_TAIL: begin
          // Extra half period lets the delayed last sample land
          half_cnt_reg <= half_cnt_reg + 3'h1;
          if (half_cnt_reg == HALF_LAST) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          ack_tog_reg <= ~ack_tog_reg;
          state_reg   <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Serial clock and master-out shifting
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_reg <= 1'b0;
      mosi_reg <= 1'b0;
      txsh_reg <= 8'h00;
    end else if (state_reg == ST_IDLE) begin
      sclk_reg <= cpol_s; // R1
      if (start && !job_reg.cfg.cpha) begin
        mosi_reg <= job_reg.tx[0]; // R7
        txsh_reg <= {1'b0, job_reg.tx[7:1]};
      end else if (start) begin
        txsh_reg <= job_reg.tx;
      end
    end else if (edge_now) begin
      sclk_reg <= ~sclk_reg; // R1
      // Phase 0 drives on trailing edges, phase 1 on leading
      if ((edge_cnt_reg[0] != cpha_reg) && !(last_edge && !cpha_reg)) begin
        mosi_reg <= txsh_reg[0]; // R7
        txsh_reg <= {1'b0, txsh_reg[7:1]};
      end
    end
  end

  // Sampling waits out the two-flop latency of the input pin
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      samp_d_reg  <= 2'b00;
      rxsh_reg    <= 8'h00;
      rx_hold_reg <= 8'h00;
    end else begin
      samp_d_reg <= {samp_d_reg[0], edge_now && (edge_cnt_reg[0] == cpha_reg)}; // R2
      if (start) begin
        rxsh_reg <= 8'h00;
      end else if (samp_d_reg[1]) begin
        rxsh_reg <= {miso_s2_reg, rxsh_reg[7:1]};
      end
      if (state_reg == ST_DONE) begin
        rx_hold_reg <= rxsh_reg >> (4'h8 - nbits_reg);
      end
    end
  end

  // Pin ownership: master first, ordinary settings otherwise
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_out_reg <= 4'h0;
      pin_oe_reg  <= 4'h0;
    end else if (en_s) begin
      pin_out_reg <= {ss_s, 1'b0, mosi_reg, sclk_reg}; // R3 R4 R5
      pin_oe_reg  <= PIN_OE_SPI; // R4
    end else begin
      pin_out_reg <= gpo_s;
      pin_oe_reg  <= gpoe_s;
    end
  end

  assign o_pin_out = pin_out_reg;
  assign o_pin_oe  = pin_oe_reg;

  // Clock toggle count per transaction, for checking only
  always_ff @(posedge i_link_clk or posedge i_rst) begin
    if (i_rst) begin
      tog_cnt_reg <= 5'h00;
    end else if (start) begin
      tog_cnt_reg <= 5'h00;
    end else if (state_reg != ST_IDLE && sclk_reg != $past(sclk_reg)) begin
      tog_cnt_reg <= tog_cnt_reg + 5'h01;
    end
  end

  property p_exe_zero;
    @(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && i_addr == EXE_OFS) |=> (o_rdata == 8'h00);
  endproperty
  a_exe_zero: assert property (p_exe_zero) else $error("execute read not zero"); // R8

  property p_go_busy;
    @(posedge i_ref_clk) disable iff (i_rst)
    go_write |=> busy ##1 o_busy;
  endproperty
  a_go_busy: assert property (p_go_busy) else $error("launch did not go busy"); // R8

  property p_done_idle_level;
    @(posedge i_link_clk) disable iff (i_rst)
    (state_reg == ST_DONE) |-> (sclk_reg == cpol_reg);
  endproperty
  a_done_idle_level: assert property (p_done_idle_level) else $error("clock not idle"); // R1

  property p_sample_edge;
    @(posedge i_link_clk) disable iff (i_rst)
    samp_d_reg[0] |-> ((sclk_reg ^ cpol_reg) == !cpha_reg);
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("sample on wrong edge"); // R2

  property p_len_eight;
    @(posedge i_link_clk) disable iff (i_rst)
    (start && job_reg.cfg.len == 3'h0) |=> (nedges_reg == 5'h10);
  endproperty
  a_len_eight: assert property (p_len_eight) else $error("code zero not eight bits"); // R6

  property p_edge_total;
    @(posedge i_link_clk) disable iff (i_rst)
    (state_reg == ST_DONE) |-> (tog_cnt_reg == {nbits_reg, 1'b0});
  endproperty
  a_edge_total: assert property (p_edge_total) else $error("wrong clock count"); // R9

  property p_mosi_first;
    @(posedge i_link_clk) disable iff (i_rst)
    (start && !job_reg.cfg.cpha) |=> (mosi_reg == job_reg.tx[0]);
  endproperty
  a_mosi_first: assert property (p_mosi_first) else $error("first bit not lsb"); // R7

  property p_owned;
    @(posedge i_link_clk) disable iff (i_rst)
    en_s |=> (o_pin_oe == PIN_OE_SPI);
  endproperty
  a_owned: assert property (p_owned) else $error("pins not owned"); // R4

  property p_ss_level;
    @(posedge i_link_clk) disable iff (i_rst)
    en_s |=> (o_pin_out[PIN_SS] == $past(ss_s));
  endproperty
  a_ss_level: assert property (p_ss_level) else $error("select level wrong"); // R3

  property p_gpio_ignored;
    @(posedge i_link_clk) disable iff (i_rst)
    en_s |=> (o_pin_out[PIN_SCLK] == $past(sclk_reg)) && !o_pin_oe[PIN_MISO];
  endproperty
  a_gpio_ignored: assert property (p_gpio_ignored) else $error("pin setting leaked"); // R5

endmodule : gsmc_top

`default_nettype wire

// File: bench/gsmc_slave.sv
// Behavioural serial slave standing on the borrowed pins
`timescale 1ns/1ps
`default_nettype none
module gsmc_slave (
  input  wire logic       i_sclk,
  input  wire logic       i_mosi,
  input  wire logic       i_sel_n,
  input  wire logic       i_cpol,
  input  wire logic       i_cpha,
  input  wire logic [7:0] i_tx,
  output logic            o_miso,
  output logic [7:0]      o_rx,
  output logic [3:0]      o_cycles
);
  int   k;
  int   j;
  logic sel_q;
  logic sclk_q;
  // One process owns every output, so no two writers race on a pin event
  initial begin
    o_miso   = 1'b0;
    o_rx     = 8'h00;
    o_cycles = 4'h0;
    k        = 0;
    j        = 0;
    sel_q    = 1'b1;
    sclk_q   = 1'b0;
    forever begin
      @(i_sclk or i_sel_n);
      if (i_sel_n === 1'b0 && sel_q !== 1'b0) begin
        // Frame start; phase 0 needs the first bit out before any edge
        o_rx     = 8'h00;
        o_cycles = 4'h0;
        j        = 0;
        k        = i_cpha ? 0 : 1;
        o_miso   = i_tx[0];
      end else if (i_sel_n !== 1'b0 && sel_q === 1'b0) begin
        // Released line floats: show the inverse so stale data never matches
        o_miso = ~o_miso;
      end else if (i_sel_n === 1'b0 && i_sclk !== sclk_q) begin
        // Leading edge leaves the idle level; phase picks sample or drive
        if (i_sclk !== i_cpol) begin
          o_cycles = o_cycles + 4'h1;
        end
        if ((i_sclk !== i_cpol) == i_cpha) begin
          if (k < 8) begin
            o_miso = i_tx[k];
            k      = k + 1;
          end
        end else if (j < 8) begin
          o_rx[j] = i_mosi;
          j       = j + 1;
        end
      end
      sel_q  = i_sel_n;
      sclk_q = i_sclk;
    end
  end
endmodule : gsmc_slave
`default_nettype wire

// File: bench/gsmc_tb.sv
// Testbench: register traffic, table of transfers, pin ownership
`timescale 1ns/1ps
`default_nettype none
module gsmc_tb;
  import gsmc_pkg::*;
  logic [11:0] i_addr;
  logic [7:0]  i_wdata, o_rdata, s_tx, s_rx, d, m, c;
  logic [3:0]  i_gpio_out, i_gpio_oe, i_pin_in, o_pin_out, o_pin_oe, s_cycles;
  logic        i_ref_clk, i_rst, i_link_clk, i_wr, i_rd, o_busy, s_miso, cpol, cpha;
  int          mismatches, comparisons, n, t;
  // Rows: config, master byte, slave byte; every length and mode
  logic [23:0] rows [8] = '{24'h08A53C, 24'h29FFFF, 24'h4A5AC3, 24'h6B9669,
                            24'h0C7E81, 24'h2DB44B, 24'h4E33CC, 24'h6FE718};

  // Master-in pin sees the slave unless the device drives it
  assign i_pin_in = {o_pin_out[3], o_pin_oe[2] ? o_pin_out[2] : s_miso, o_pin_out[1:0]};

  gsmc_top gsmc_top_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_link_clk(i_link_clk),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_gpio_out(i_gpio_out), .i_gpio_oe(i_gpio_oe), .i_pin_in(i_pin_in),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_busy(o_busy));
  gsmc_slave gsmc_slave_inst (.i_sclk(o_pin_out[PIN_SCLK]), .i_mosi(o_pin_out[PIN_MOSI]),
    .i_sel_n(o_pin_out[PIN_SS]), .i_cpol(cpol), .i_cpha(cpha), .i_tx(s_tx),
    .o_miso(s_miso), .o_rx(s_rx), .o_cycles(s_cycles));

  // Clocks unrelated in phase
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_link_clk = 1'b0;
    #3.3;
    forever #7.5 i_link_clk = ~i_link_clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string nm);
    logic [7:0] v;
    rd(a, v);
    chk(nm, v, exp);
  endtask : rdc
  // Enable and select cross by two flops plus the output flop
  task automatic settle();
    repeat (8) @(posedge i_link_clk);
    @(posedge i_ref_clk);
  endtask : settle
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    {i_wr, i_rd, cpol, cpha} = 4'h0;
    i_addr = 12'h000;
    i_wdata = 8'h00;
    s_tx = 8'h00;
    i_gpio_out = 4'hA;
    i_gpio_oe = 4'h9;
    i_rst = 1'b1;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rdc(CFG_OFS, CFG_RST, "cfg reset");
    rdc(TX_OFS, TX_RST, "tx reset");
    rdc(12'h100, ZERO_BYTE, "unmapped");
    settle();
    chk("gpio out", {4'h0, o_pin_out}, 8'h0A);
    chk("gpio oe", {4'h0, o_pin_oe}, 8'h09);
    wr(EXE_OFS, 8'h01);
    rdc(STAT_OFS, ZERO_BYTE, "launch while off");
    chk("busy while off", {7'h0, o_busy}, 8'h00);
    @(posedge i_ref_clk);
    i_gpio_out <= 4'h5;
    i_gpio_oe <= 4'h6;
    foreach (rows[r]) begin
      c = rows[r][23:16];
      n = (c[2:0] == 3'h0) ? 8 : int'(c[2:0]);
      m = 8'hFF >> (8 - n);
      cpol = c[CPOL_BIT];
      cpha = c[CPHA_BIT];
      s_tx = rows[r][7:0];
      wr(CFG_OFS, c | 8'h10);
      settle();
      chk("idle clock", {7'h0, o_pin_out[PIN_SCLK]}, {7'h0, c[CPOL_BIT]});
      chk("pin owner", {4'h0, o_pin_oe}, {4'h0, PIN_OE_SPI});
      wr(CFG_OFS, c);
      settle();
      chk("select", {7'h0, o_pin_out[PIN_SS]}, 8'h00);
      rdc(CFG_OFS, c, "cfg readback");
      wr(TX_OFS, rows[r][15:8]);
      // Second launch lands while busy and must be ignored
      wr(EXE_OFS, 8'h01);
      wr(EXE_OFS, 8'h01);
      rdc(EXE_OFS, ZERO_BYTE, "execute reads");
      chk("busy flag", {7'h0, o_busy}, 8'h01);
      for (t = 0; t < 300; t++) begin
        rd(STAT_OFS, d);
        if (d[BUSY_BIT] === 1'b0) break;
      end
      if (t == 300) begin
        mismatches++;
        finish_test();
      end
      chk("busy clear", {7'h0, o_busy}, 8'h00);
      rdc(RX_OFS, s_tx & m, "received");
      chk("sent", s_rx, rows[r][15:8] & m);
      chk("clock cycles", {4'h0, s_cycles}, 8'(n));
      chk("select kept", {7'h0, o_pin_out[PIN_SS]}, 8'h00);
      chk("idle after", {7'h0, o_pin_out[PIN_SCLK]}, {7'h0, c[CPOL_BIT]});
    end
    // Reserved top bit stays zero; disabling returns the pins
    wr(CFG_OFS, 8'h80);
    rdc(CFG_OFS, ZERO_BYTE, "reserved bit");
    settle();
    chk("pins back", {o_pin_oe, o_pin_out}, 8'h65);
    finish_test();
  end

  // Hang guard
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
endmodule : gsmc_tb
`default_nettype wire
